//--- design/rmii_pkg.sv
package rmii_pkg;
    // core clock and interface clock rates
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned IFACE_HZ = 50_000_000;
    // core cycles per half period of the sourced interface clock
    localparam int unsigned CLKOUT_HALF = CLK_HZ / (2 * IFACE_HZ);
    localparam int unsigned CLKOUT_CNT_W = 4;

    // line speed encodings
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // at 10 Mbps each dibit stands for this many interface clock rising edges
    localparam logic [3:0] SLOW_REPEAT = 4'hA;
    localparam logic [1:0] DIBIT_LAST = 2'h3;

    // transmit pattern with enable low and error high that asks for low power idle
    localparam logic [1:0] LPI_DIBIT = 2'h1;

    // reference oscillator frequency select codes
    localparam logic [1:0] REF_25MHZ = 2'h0;
    localparam logic [1:0] REF_50MHZ = 2'h1;
    localparam logic [1:0] REF_125MHZ = 2'h2;

    // values after reset
    localparam logic CLKOUT_EN_RST = 1'b1;
    localparam logic REDUCED_MODE_RST = 1'b0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] DIBIT_RST = 2'h0;

    // receive buffer entry layout: {last, err, data}
    localparam int unsigned RX_ENTRY_W = 10;
    localparam int unsigned RX_ENTRY_LAST = 9;
    localparam int unsigned RX_ENTRY_ERR = 8;
    localparam int unsigned RX_BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SEND = 2'b01,
        RX_FAULT = 2'b10
    } rmii_rx_state_t;
endpackage

//--- design/rmii_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module rmii_buf2
    import rmii_pkg::*;
#(
    parameter int unsigned WIDTH = RX_ENTRY_W,
    parameter int unsigned DEPTH = RX_BUF_DEPTH
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic [PW-1:0] nxt_wr;
    logic [PW-1:0] nxt_rd;
    logic [PW:0] nxt_cnt;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push)
        begin
            nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop)
        begin
            nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_cnt = cnt_ff + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // storage carries no reset; only the pointers and the count define what is valid
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule
`default_nettype wire

//--- design/rmii_port.sv
// Behaviour
// - reduced mode carries traffic only at 10 and 100 Mbps, never gigabit.
// - transmit dibit on data pins 1..0, enable on control pin, error on pin 3.
// - receive dibit on data pins 1..0, error on pin 3, carrier/valid on control pin.
// - MAC drives transmit error; device uses it for low power idle signalling.
// - interface clock comes from the system or is sourced by the device at 50 MHz.
// - any phase between interface clock input and reference input is tolerated.
// - clock output enabled after reset; disable bit turns it off when unused.
// - device-clocked case runs from 25 MHz crystal or 25/50/125 MHz reference.
// - device-clocked case drives an enabled 50 MHz clock on the clock output.
// - reduced versus full interface family is taken from a strap at reset.
`timescale 1ns/1ps
`default_nettype none
module rmii_port
    import rmii_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic strap_reduced_mode,
    input wire logic clock_from_device,
    input wire logic clkout_disable,
    input wire logic osc_ref_is_crystal,
    input wire logic [1:0] osc_ref_mhz_sel,
    input wire logic [1:0] line_speed,
    input wire logic iface_clock_input,
    output logic iface_clock_output,
    input wire logic [1:0] tx_dibit,
    input wire logic tx_enable,
    input wire logic tx_error,
    output logic [1:0] rx_dibit,
    output logic rx_error,
    output logic crs_dv,
    output logic [7:0] tx_byte,
    output logic tx_byte_err,
    output logic tx_byte_valid,
    output logic tx_frame_active,
    output logic lpi_request,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_err,
    input wire logic rx_in_last,
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    output logic reduced_mode,
    output logic speed_ok,
    output logic ref_config_ok
);
    // pin synchroniser: {arrangement, strap, clk, en, err, dibit}
    localparam int unsigned SYNC_W = 7;
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic clk_s;
    logic en_s;
    logic err_s;
    logic [1:0] dibit_s;
    logic strap_s;
    logic arr_s;

    logic [3:0] pin_prev_ff;

    always_ff @(posedge clock)
    begin
        sync1_ff <= {clock_from_device, strap_reduced_mode, iface_clock_input,
                     tx_enable, tx_error, tx_dibit};
        sync2_ff <= sync1_ff;
        pin_prev_ff <= sync2_ff[3:0];
    end

    // clock and data take the same two stages; data then waits one more, so a
    // detected rise uses the value that stood before that edge, not the one the
    // far side launches on it, whatever the phase of the two clocks
    assign {arr_s, strap_s, clk_s} = sync2_ff[6:4];
    assign {en_s, err_s, dibit_s} = pin_prev_ff;

    // strap is followed while reset holds and frozen from the release on
    logic mode_ff;
    logic nxt_mode;
    always_comb
    begin
        nxt_mode = !rst_n ? strap_s : mode_ff;
    end
    always_ff @(posedge clock)
    begin
        mode_ff <= nxt_mode;
    end
    assign reduced_mode = mode_ff;

    // link enable: reduced family and a 10/100 speed only
    logic run;
    logic slow;
    assign speed_ok = (line_speed == SPEED_10) || (line_speed == SPEED_100);
    assign slow = (line_speed == SPEED_10);
    assign run = mode_ff && speed_ok;

    // reference configuration check for the device-clocked arrangement
    assign ref_config_ok = osc_ref_is_crystal ? (osc_ref_mhz_sel == REF_25MHZ) :
                           (osc_ref_mhz_sel == REF_25MHZ) ||
                           (osc_ref_mhz_sel == REF_50MHZ) ||
                           (osc_ref_mhz_sel == REF_125MHZ);

    // rising edge of the interface clock and the 10 Mbps repeat divider
    logic clk_prev_ff;
    logic [3:0] rep_ff;
    logic [3:0] nxt_rep;
    logic rise;
    logic tick;
    assign rise = clk_s && !clk_prev_ff;
    assign tick = rise && (!slow || (rep_ff == SLOW_REPEAT - 4'h1));

    always_comb
    begin
        nxt_rep = rep_ff;
        if (!run)
        begin
            nxt_rep = 4'h0;
        end
        else if (rise)
        begin
            nxt_rep = (rep_ff == SLOW_REPEAT - 4'h1) ? 4'h0 : rep_ff + 4'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // follow the pin in reset so no false rise appears at release
            clk_prev_ff <= clk_s;
            rep_ff <= 4'h0;
        end
        else
        begin
            clk_prev_ff <= clk_s;
            rep_ff <= nxt_rep;
        end
    end

    // sourced interface clock: core clock divided down to 50 MHz
    logic [CLKOUT_CNT_W-1:0] div_ff;
    logic [CLKOUT_CNT_W-1:0] nxt_div;
    logic clkout_ff;
    logic nxt_clkout;
    logic clkout_en;
    // device-clocked keeps it on; otherwise enabled from reset until disabled
    assign clkout_en = arr_s ? 1'b1 : !clkout_disable;

    always_comb
    begin
        nxt_div = div_ff;
        nxt_clkout = clkout_ff;
        if (!clkout_en)
        begin
            nxt_div = '0;
            nxt_clkout = 1'b0;
        end
        else if (div_ff == CLKOUT_CNT_W'(CLKOUT_HALF - 1))
        begin
            nxt_div = '0;
            nxt_clkout = !clkout_ff;
        end
        else
        begin
            nxt_div = div_ff + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            div_ff <= '0;
            clkout_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            clkout_ff <= nxt_clkout;
        end
    end
    assign iface_clock_output = clkout_ff;

    // transmit: dibits collected least significant first into bytes
    logic [7:0] tx_sh_ff;
    logic [7:0] nxt_tx_sh;
    logic [1:0] tx_cnt_ff;
    logic [1:0] nxt_tx_cnt;
    logic tx_err_acc_ff;
    logic nxt_tx_err_acc;
    logic [7:0] tx_byte_ff;
    logic [7:0] nxt_tx_byte;
    logic tx_berr_ff;
    logic nxt_tx_berr;
    logic tx_bval_ff;
    logic nxt_tx_bval;
    logic tx_act_ff;
    logic nxt_tx_act;
    logic lpi_ff;
    logic nxt_lpi;

    always_comb
    begin
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_err_acc = tx_err_acc_ff;
        nxt_tx_byte = tx_byte_ff;
        nxt_tx_berr = tx_berr_ff;
        nxt_tx_bval = 1'b0;
        nxt_tx_act = tx_act_ff;
        nxt_lpi = lpi_ff;
        if (!run)
        begin
            nxt_tx_cnt = 2'h0;
            nxt_tx_err_acc = 1'b0;
            nxt_tx_act = 1'b0;
            nxt_lpi = 1'b0;
        end
        else if (tick)
        begin
            nxt_tx_act = en_s;
            // low power idle: enable low, error high, fixed dibit
            nxt_lpi = !en_s && err_s && (dibit_s == LPI_DIBIT);
            if (en_s)
            begin
                nxt_tx_sh = {dibit_s, tx_sh_ff[7:2]};
                nxt_tx_cnt = tx_cnt_ff + 2'h1;
                nxt_tx_err_acc = tx_err_acc_ff || err_s;
                if (tx_cnt_ff == DIBIT_LAST)
                begin
                    nxt_tx_byte = {dibit_s, tx_sh_ff[7:2]};
                    nxt_tx_berr = tx_err_acc_ff || err_s;
                    nxt_tx_bval = 1'b1;
                    nxt_tx_err_acc = 1'b0;
                end
            end
            else
            begin
                // a partial byte at frame end is dropped
                nxt_tx_cnt = 2'h0;
                nxt_tx_err_acc = 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tx_sh_ff <= BYTE_RST;
            tx_cnt_ff <= 2'h0;
            tx_err_acc_ff <= 1'b0;
            tx_byte_ff <= BYTE_RST;
            tx_berr_ff <= 1'b0;
            tx_bval_ff <= 1'b0;
            tx_act_ff <= 1'b0;
            lpi_ff <= 1'b0;
        end
        else
        begin
            tx_sh_ff <= nxt_tx_sh;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_err_acc_ff <= nxt_tx_err_acc;
            tx_byte_ff <= nxt_tx_byte;
            tx_berr_ff <= nxt_tx_berr;
            tx_bval_ff <= nxt_tx_bval;
            tx_act_ff <= nxt_tx_act;
            lpi_ff <= nxt_lpi;
        end
    end
    assign tx_byte = tx_byte_ff;
    assign tx_byte_err = tx_berr_ff;
    assign tx_byte_valid = tx_bval_ff;
    assign tx_frame_active = tx_act_ff;
    assign lpi_request = lpi_ff;

    // receive: buffered bytes serialised onto the interface pins
    logic [RX_ENTRY_W-1:0] buf_data;
    logic buf_valid;
    logic buf_pop;

    rmii_buf2 #(
        .WIDTH(RX_ENTRY_W),
        .DEPTH(RX_BUF_DEPTH)
    ) u_rx_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_data({rx_in_last, rx_in_err, rx_in_data}),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(buf_pop)
    );

    rmii_rx_state_t rx_st_ff;
    rmii_rx_state_t nxt_rx_st;
    logic [7:0] rx_sh_ff;
    logic [7:0] nxt_rx_sh;
    logic [1:0] rx_cnt_ff;
    logic [1:0] nxt_rx_cnt;
    logic rx_last_ff;
    logic nxt_rx_last;
    logic rx_berr_ff;
    logic nxt_rx_berr;
    logic [1:0] rxd_ff;
    logic [1:0] nxt_rxd;
    logic rxer_ff;
    logic nxt_rxer;
    logic crs_ff;
    logic nxt_crs;

    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_last = rx_last_ff;
        nxt_rx_berr = rx_berr_ff;
        nxt_rxd = rxd_ff;
        nxt_rxer = rxer_ff;
        nxt_crs = crs_ff;
        buf_pop = 1'b0;
        if (!run)
        begin
            nxt_rx_st = RX_IDLE;
            nxt_rxd = DIBIT_RST;
            nxt_rxer = 1'b0;
            nxt_crs = 1'b0;
        end
        else if (tick)
        begin
            case (rx_st_ff)
                RX_IDLE:
                begin
                    nxt_rxd = DIBIT_RST;
                    nxt_rxer = 1'b0;
                    nxt_crs = 1'b0;
                    if (buf_valid)
                    begin
                        buf_pop = 1'b1;
                        nxt_rx_sh = {2'h0, buf_data[7:2]};
                        nxt_rx_last = buf_data[RX_ENTRY_LAST];
                        nxt_rx_berr = buf_data[RX_ENTRY_ERR];
                        nxt_rxd = buf_data[1:0];
                        nxt_rxer = buf_data[RX_ENTRY_ERR];
                        nxt_crs = 1'b1;
                        nxt_rx_cnt = 2'h1;
                        nxt_rx_st = RX_SEND;
                    end
                end
                RX_SEND:
                begin
                    if (rx_cnt_ff != 2'h0)
                    begin
                        nxt_rxd = rx_sh_ff[1:0];
                        nxt_rx_sh = {2'h0, rx_sh_ff[7:2]};
                        nxt_rx_cnt = (rx_cnt_ff == DIBIT_LAST) ? 2'h0 : rx_cnt_ff + 2'h1;
                    end
                    else if (rx_last_ff)
                    begin
                        nxt_rxd = DIBIT_RST;
                        nxt_rxer = 1'b0;
                        nxt_crs = 1'b0;
                        nxt_rx_st = RX_IDLE;
                    end
                    else if (buf_valid)
                    begin
                        buf_pop = 1'b1;
                        nxt_rx_sh = {2'h0, buf_data[7:2]};
                        nxt_rx_last = buf_data[RX_ENTRY_LAST];
                        nxt_rx_berr = buf_data[RX_ENTRY_ERR];
                        nxt_rxd = buf_data[1:0];
                        nxt_rxer = buf_data[RX_ENTRY_ERR];
                        nxt_rx_cnt = 2'h1;
                    end
                    else
                    begin
                        // underrun mid-frame: flag one error slot, then end frame
                        nxt_rxd = DIBIT_RST;
                        nxt_rxer = 1'b1;
                        nxt_rx_st = RX_FAULT;
                    end
                end
                RX_FAULT:
                begin
                    nxt_rxd = DIBIT_RST;
                    nxt_rxer = 1'b0;
                    nxt_crs = 1'b0;
                    nxt_rx_st = RX_IDLE;
                end
                default:
                begin
                    nxt_rx_st = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rx_st_ff <= RX_IDLE;
            rx_sh_ff <= BYTE_RST;
            rx_cnt_ff <= 2'h0;
            rx_last_ff <= 1'b0;
            rx_berr_ff <= 1'b0;
            rxd_ff <= DIBIT_RST;
            rxer_ff <= 1'b0;
            crs_ff <= 1'b0;
        end
        else
        begin
            rx_st_ff <= nxt_rx_st;
            rx_sh_ff <= nxt_rx_sh;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_last_ff <= nxt_rx_last;
            rx_berr_ff <= nxt_rx_berr;
            rxd_ff <= nxt_rxd;
            rxer_ff <= nxt_rxer;
            crs_ff <= nxt_crs;
        end
    end
    assign rx_dibit = rxd_ff;
    assign rx_error = rxer_ff;
    assign crs_dv = crs_ff;
endmodule
`default_nettype wire

//--- tb/rmii_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module rmii_port_props
    import rmii_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_from_device,
    input wire logic clkout_disable,
    input wire logic osc_ref_is_crystal,
    input wire logic [1:0] osc_ref_mhz_sel,
    input wire logic [1:0] line_speed,
    input wire logic iface_clock_output,
    input wire logic [1:0] rx_dibit,
    input wire logic crs_dv,
    input wire logic tx_byte_valid,
    input wire logic tx_frame_active,
    input wire logic lpi_request,
    input wire logic reduced_mode,
    input wire logic speed_ok,
    input wire logic ref_config_ok
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    speed_check_a: assert property (speed_ok == (line_speed < SPEED_1000))
        else $error("speed_ok disagrees with line_speed");
    gig_idle_a: assert property ((line_speed == SPEED_1000) [*2] |-> !tx_byte_valid)
        else $error("byte delivered at gigabit speed");
    strap_idle_a: assert property (!reduced_mode |-> !tx_byte_valid && !crs_dv)
        else $error("traffic while not in reduced mode");
    strap_hold_a: assert property ($stable(reduced_mode))
        else $error("reduced_mode moved after reset");
    refsel_check_a: assert property (ref_config_ok == (osc_ref_is_crystal ?
        osc_ref_mhz_sel == REF_25MHZ : osc_ref_mhz_sel != 2'h3))
        else $error("ref_config_ok wrong");
    clkout_off_a: assert property ((!clock_from_device && clkout_disable) [*5]
        |-> !iface_clock_output)
        else $error("clock output runs while disabled");
    clkout_run_a: assert property ((clock_from_device || !clkout_disable) [*6]
        |-> iface_clock_output != $past(iface_clock_output, 2))
        else $error("clock output not at a quarter of core rate");
    byte_pulse_a: assert property (tx_byte_valid |=> !tx_byte_valid [*8])
        else $error("byte valid longer than one pulse");
    byte_frame_a: assert property (tx_byte_valid |-> tx_frame_active)
        else $error("byte valid outside a frame");
    lpi_excl_a: assert property (lpi_request |-> !tx_frame_active)
        else $error("low power request inside a frame");
    rx_hold_a: assert property ($changed(rx_dibit) |=> $stable(rx_dibit) [*8])
        else $error("receive dibit changed between ticks");

    cover property (tx_byte_valid);
    cover property (lpi_request);
    cover property ($rose(crs_dv));
endmodule

bind rmii_port rmii_port_props u_props (
    .clock(clock), .rst_n(rst_n), .clock_from_device(clock_from_device),
    .clkout_disable(clkout_disable), .osc_ref_is_crystal(osc_ref_is_crystal),
    .osc_ref_mhz_sel(osc_ref_mhz_sel), .line_speed(line_speed),
    .iface_clock_output(iface_clock_output), .rx_dibit(rx_dibit), .crs_dv(crs_dv),
    .tx_byte_valid(tx_byte_valid), .tx_frame_active(tx_frame_active),
    .lpi_request(lpi_request), .reduced_mode(reduced_mode), .speed_ok(speed_ok),
    .ref_config_ok(ref_config_ok)
);
`default_nettype wire

//--- tb/rmii_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmii_mac_model (
    input wire logic iface_clk,
    output logic [1:0] tx_dibit,
    output logic tx_enable,
    output logic tx_error,
    input wire logic [1:0] rx_dibit,
    input wire logic rx_error,
    input wire logic crs_dv
);
    logic [7:0] rx_sh;
    logic rx_err_sh;
    int rx_cnt = 0;
    logic [8:0] rx_q[$];

    initial
    begin
        tx_dibit = 2'h0;
        tx_enable = 1'b0;
        tx_error = 1'b0;
    end

    // at 10 Mbps each dibit stands rep rises, so any divider phase sees it once
    task automatic drive(input logic [1:0] d, input logic en, input logic er, input int rep);
        repeat (rep)
        begin
            @(posedge iface_clk);
            tx_dibit <= d;
            tx_enable <= en;
            tx_error <= er;
        end
    endtask

    task automatic send(input logic [7:0] b, input logic er, input int rep);
        for (int k = 0; k < 4; k++)
            drive(b[2*k +: 2], 1'b1, er, rep);
    endtask

    // data lines show the inverse of the last dibit, so stale values never match
    task automatic idle(input int rep);
        drive(~tx_dibit, 1'b0, 1'b0, rep);
    endtask

    always @(posedge iface_clk)
        if (crs_dv === 1'b1)
        begin
            rx_sh = {rx_dibit, rx_sh[7:2]};
            rx_err_sh = rx_error;
            rx_cnt = rx_cnt + 1;
            if (rx_cnt == 4)
            begin
                rx_q.push_back({rx_err_sh, rx_sh});
                rx_cnt = 0;
            end
        end
        else
            rx_cnt = 0;
endmodule
`default_nettype wire

//--- tb/rmii_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module rmii_port_test;
    import rmii_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic iface_clk = 1'b0;
    logic strap = 1'b1;
    logic dev_clk = 1'b0;
    logic clk_dis = 1'b0;
    logic xtal = 1'b0;
    logic [1:0] ref_sel = 2'h0;
    logic [1:0] speed = SPEED_100;
    logic [7:0] in_data = 8'h00;
    logic in_err = 1'b0;
    logic in_last = 1'b0;
    logic in_valid = 1'b0;
    logic [1:0] tx_dibit, rx_dibit;
    logic [7:0] tx_byte;
    logic tx_enable, tx_error, clkout, rx_error, crs_dv, tx_byte_err, tx_byte_valid;
    logic tx_frame_active, lpi_request, rx_in_ready, reduced_mode, speed_ok, ref_config_ok;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [8:0] txq[$];

    initial
    begin
        forever #2.5 clock = ~clock;
    end
    // odd offset keeps the interface clock out of phase with the core clock
    initial
    begin
        #1.3;
        forever #62.5 iface_clk = ~iface_clk;
    end

    rmii_port u_dut (
        .clock(clock), .rst_n(rst_n), .strap_reduced_mode(strap),
        .clock_from_device(dev_clk), .clkout_disable(clk_dis), .osc_ref_is_crystal(xtal),
        .osc_ref_mhz_sel(ref_sel), .line_speed(speed), .iface_clock_input(iface_clk),
        .iface_clock_output(clkout), .tx_dibit(tx_dibit), .tx_enable(tx_enable),
        .tx_error(tx_error), .rx_dibit(rx_dibit), .rx_error(rx_error), .crs_dv(crs_dv),
        .tx_byte(tx_byte), .tx_byte_err(tx_byte_err), .tx_byte_valid(tx_byte_valid),
        .tx_frame_active(tx_frame_active), .lpi_request(lpi_request),
        .rx_in_data(in_data), .rx_in_err(in_err), .rx_in_last(in_last),
        .rx_in_valid(in_valid), .rx_in_ready(rx_in_ready), .reduced_mode(reduced_mode),
        .speed_ok(speed_ok), .ref_config_ok(ref_config_ok)
    );
    rmii_mac_model u_mac (
        .iface_clk(iface_clk), .tx_dibit(tx_dibit), .tx_enable(tx_enable),
        .tx_error(tx_error), .rx_dibit(rx_dibit), .rx_error(rx_error), .crs_dv(crs_dv)
    );

    always @(negedge clock)
        if (tx_byte_valid === 1'b1)
            txq.push_back({tx_byte_err, tx_byte});

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("mismatches=%0d compares=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset(input logic s);
        @(negedge clock);
        strap = s;
        rst_n = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
    endtask

    task automatic t_static;
        for (int c = 0; c < 8; c++)
        begin
            @(negedge clock);
            speed = 2'(c);
            {xtal, ref_sel} = 3'(c);
            #1;
            check(32'(speed_ok), 32'(c[1:0] < 2));
            check(32'(ref_config_ok), 32'(c < 3 || c == 4));
        end
        @(negedge clock);
        {xtal, ref_sel} = 3'h0;
    endtask

    task automatic t_clkout(input logic dev, input logic dis, input int exp);
        int n;
        logic p;
        n = 0;
        @(negedge clock);
        dev_clk = dev;
        clk_dis = dis;
        repeat (8) @(negedge clock);
        p = clkout;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clock);
            if (clkout !== p)
                n++;
            p = clkout;
        end
        check(32'(n), 32'(exp));
        if (exp == 0)
            check(32'(clkout), 32'h0);
    endtask

    task automatic t_tx(input logic [1:0] spd, input int rep, input int nexp);
        @(negedge clock);
        speed = spd;
        txq.delete();
        u_mac.send(8'hA5, 1'b0, rep);
        check(32'(tx_frame_active), 32'(nexp == 2));
        u_mac.send(8'h3C, 1'b1, rep);
        u_mac.idle(rep * 2);
        check(32'(txq.size()), 32'(nexp));
        if (nexp == 2)
        begin
            check(32'(txq[0]), 32'h0A5);
            check(32'(txq[1]), 32'h13C);
        end
    endtask

    task automatic t_lpi;
        @(negedge clock);
        speed = SPEED_100;
        u_mac.drive(LPI_DIBIT, 1'b0, 1'b1, 3);
        check(32'(lpi_request), 32'h1);
        u_mac.drive(2'h2, 1'b0, 1'b0, 3);
        check(32'(lpi_request), 32'h0);
    endtask

    task automatic push(input logic [8:0] v, input logic last, input logic full);
        @(negedge clock);
        {in_err, in_data} = v;
        in_last = last;
        in_valid = 1'b1;
        if (full)
            check(32'(rx_in_ready), 32'h0);
        for (int w = 0; w < 300 && rx_in_ready !== 1'b1; w++)
            @(negedge clock);
        check(32'(rx_in_ready), 32'h1);
        @(negedge clock);
        in_valid = 1'b0;
    endtask

    task automatic t_rx;
        logic [8:0] b[4];
        b = '{9'h1C3, 9'h05A, 9'h0F0, 9'h13E};
        u_mac.rx_q.delete();
        push(b[0], 1'b0, 1'b0);
        for (int w = 0; w < 100 && crs_dv !== 1'b1; w++)
            @(negedge clock);
        push(b[1], 1'b0, 1'b0);
        push(b[2], 1'b0, 1'b0);
        // pops come only every fourth tick, so the next word finds both entries taken
        push(b[3], 1'b1, 1'b1);
        for (int w = 0; w < 2000 && u_mac.rx_q.size() < 4; w++)
            @(negedge clock);
        repeat (60) @(negedge clock);
        check(32'(crs_dv), 32'h0);
        check(32'(u_mac.rx_q.size()), 32'h4);
        foreach (u_mac.rx_q[i])
            check(32'(u_mac.rx_q[i]), 32'(b[i]));
    endtask

    // one byte without last: the buffer runs dry and the frame ends in an error slot
    task automatic t_under;
        u_mac.rx_q.delete();
        push(9'h05A, 1'b0, 1'b0);
        for (int w = 0; w < 300 && rx_error !== 1'b1; w++)
            @(negedge clock);
        check(32'({crs_dv, rx_dibit}), 32'h4);
        repeat (30) @(negedge clock);
        check(32'(crs_dv), 32'h0);
        check(32'(u_mac.rx_q.size()), 32'h1);
        check(32'(u_mac.rx_q[0]), 32'h05A);
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test;
    end

    initial
    begin
        do_reset(1'b1);
        check(32'(reduced_mode), 32'h1);
        t_static;
        t_clkout(1'b0, 1'b0, 20);
        t_clkout(1'b1, 1'b0, 20);
        t_clkout(1'b1, 1'b1, 20);
        t_clkout(1'b0, 1'b1, 0);
        t_tx(SPEED_100, 1, 2);
        t_tx(SPEED_10, 10, 2);
        t_tx(SPEED_1000, 1, 0);
        t_lpi;
        t_rx;
        t_under;
        do_reset(1'b0);
        check(32'(reduced_mode), 32'h0);
        t_tx(SPEED_100, 1, 0);
        end_of_test;
    end
endmodule
`default_nettype wire
